// ===== src/astp_pkg.sv
/*
 * constants for the serial audio tdm port: register offsets, field
 * positions, reset values and frame formats.
 * assumes a 5-bit byte address on the register port, 32-bit data.
 */
package astp_pkg;
   // register byte offsets
   localparam logic [4:0] A_CTRL = 5'h00;
   localparam logic [4:0] A_FRAME = 5'h04;
   localparam logic [4:0] A_TXMASK = 5'h08;
   localparam logic [4:0] A_RXMASK = 5'h0c;
   localparam logic [4:0] A_STAT = 5'h10;
   localparam logic [4:0] A_MDIV = 5'h14;
   // control fields
   localparam int C_EN = 0;
   localparam int C_MST = 1;
   localparam int C_TX = 2;
   localparam int C_RX = 3;
   localparam int C_HIZ = 4;
   localparam int C_FMT = 5;
   localparam int C_CRST = 8;
   // frame fields: slots-1, slot width-1, word length-1
   localparam int F_SLOTS = 0;
   localparam int F_SW = 4;
   localparam int F_WL = 9;
   // status fields
   localparam int S_IRQ = 0;
   localparam int S_UND = 1;
   localparam int S_OVR = 2;
   // reset values: codec held in reset, stereo 32-bit slots, 16-bit words
   localparam logic [8:0] CTRL_RST = 9'h100;
   localparam logic [13:0] FRAME_RST = 14'h1ff1;
   localparam logic [15:0] MASK_RST = 16'h0003;
   localparam logic [7:0] MDIV_RST = 8'h01;
   // highest serial clock rate the port is built for
   localparam int MAX_BCLK_KHZ = 49152;
   typedef enum logic [2:0] {
      fmt_i2s = 3'h0,
      left_justified_format = 3'h1,
      right_justified_format = 3'h2,
      fmt_pcm_short = 3'h3,
      fmt_pcm_long = 3'h4
   } astp_fmt_e;
endpackage

// ===== src/astp_top.sv
/*
 * serial audio port with i2s, justified, pulse and tdm frames,
 * register port on clk, bit-level logic on link_clk.
 * assumes frame_sync_in and serial_in are timed to link_clk, and that
 * frame and format settings change only while the port is disabled.
 */
// Implementation choices: the register offsets and the plain strobed port.
// Functional notes
// [RULE1] i2s, left, right justified and pulse formats, as master or slave.
// [RULE2] short pcm frame pulse is one bit clock wide.
// [RULE3] long pcm frame pulse is two bit clocks wide.
// [RULE4] transmit and receive slot masks are set independently.
// [RULE5] slot count per frame is set, any slot subset chosen.
// [RULE6] optional high impedance output outside transmit slots.
// [RULE7] ready/valid pacing on sample streams, idle slots keep alignment.
// [RULE8] full duplex or one direction only.
// [RULE9] serial clock up to 49.152 mhz.
// [RULE10] master drives frame sync and bit clock, slave takes them.
// [RULE11] codec master clock and reset out, codec interrupt in.
// [RULE12] sampled frame pulse marks first bit of slot zero.
module astp_top #(
   parameter int MDIV_W = 8
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [4:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic [31:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   output logic [31:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   input wire logic link_clk,
   input wire logic frame_sync_in,
   output logic frame_sync_out,
   output logic frame_sync_oe,
   output logic bit_clk_out,
   output logic bit_clk_oe,
   input wire logic serial_in,
   output logic serial_out,
   output logic serial_out_oe,
   output logic codec_master_clock,
   output logic codec_reset_out,
   input wire logic codec_interrupt_in
);
   if (MDIV_W < 1 || MDIV_W > 8) $error("MDIV_W must be 1 to 8");

   typedef struct packed {
      logic [8:0] ctrl;
      logic [13:0] frame;
      logic [15:0] txm;
      logic [15:0] rxm;
      logic [MDIV_W-1:0] mdiv;
      logic [MDIV_W-1:0] mcnt;
      logic mclk;
      logic und;
      logic ovr;
      logic irq_s1;
      logic irq_s2;
      logic [31:0] rdata;
      logic [31:0] tx_hold;
      logic tx_req;
      logic txa_s1;
      logic txa_s2;
      logic rxr_s1;
      logic rxr_s2;
      logic rx_ack;
      logic und_s1;
      logic und_s2;
      logic und_s3;
      logic ovr_s1;
      logic ovr_s2;
      logic ovr_s3;
   } astp_cs_s;

   typedef struct packed {
      logic en_s1;
      logic en_s2;
      logic lock;
      logic txr_s1;
      logic txr_s2;
      logic tx_ack;
      logic rxa_s1;
      logic rxa_s2;
      logic rx_req;
      logic [31:0] rx_hold;
      logic [31:0] rx_sh;
      logic [31:0] tx_word;
      logic und_t;
      logic ovr_t;
      logic [3:0] slot;
      logic [4:0] bitc;
      logic fs_prev;
      logic fs_o;
      logic so;
      logic soe;
   } astp_ls_s;

   astp_cs_s cs, next_cs;
   astp_ls_s ls, next_ls;
   logic [1:0] lrst;
   logic wr_stat;
   logic l_start;
   astp_pkg::astp_fmt_e fmt;
   logic [3:0] nsl;
   logic [4:0] sw;
   logic [4:0] wl;
   logic mst;

   // bit offset from the word msb for slot bit b, with a valid flag
   function automatic logic [5:0] dpos(input astp_pkg::astp_fmt_e f, input logic [4:0] b,
                                       input logic [4:0] w, input logic [4:0] l);
      logic [4:0] o;
      logic v;
      o = b;
      v = b <= l;
      case (f)
         astp_pkg::fmt_i2s: begin
            o = b - 5'h01;
            v = (b != 5'h00) && (o <= l);
         end
         astp_pkg::right_justified_format: begin
            o = b - (w - l);
            v = b >= (w - l);
         end
         default: begin
            o = b;
         end
      endcase
      return {v, o};
   endfunction

   // master frame sync level for a bit position
   function automatic logic fsv(input astp_pkg::astp_fmt_e f, input logic [3:0] s, input logic [4:0] b);
      case (f)
         astp_pkg::fmt_i2s: fsv = s != 4'h0;
         astp_pkg::fmt_pcm_short: fsv = (s == 4'h0) && (b == 5'h00); // RULE2
         astp_pkg::fmt_pcm_long: fsv = (s == 4'h0) && (b <= 5'h01); // RULE3
         default: fsv = s == 4'h0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////
   // shared decode of the static settings
   assign fmt = astp_pkg::astp_fmt_e'(cs.ctrl[astp_pkg::C_FMT+:3]); // RULE1
   assign nsl = (fmt <= astp_pkg::right_justified_format) ? 4'h1 : cs.frame[astp_pkg::F_SLOTS+:4]; // RULE5
   assign sw = cs.frame[astp_pkg::F_SW+:5];
   assign wl = cs.frame[astp_pkg::F_WL+:5];
   assign mst = cs.ctrl[astp_pkg::C_MST];
   assign wr_stat = wr && (addr == astp_pkg::A_STAT);

   // register side: bus, stream handshakes, codec pins
   always_comb begin
      next_cs = cs;
      next_cs.irq_s1 = codec_interrupt_in;
      next_cs.irq_s2 = cs.irq_s1;
      next_cs.txa_s1 = ls.tx_ack;
      next_cs.txa_s2 = cs.txa_s1;
      next_cs.rxr_s1 = ls.rx_req;
      next_cs.rxr_s2 = cs.rxr_s1;
      next_cs.und_s1 = ls.und_t;
      next_cs.und_s2 = cs.und_s1;
      next_cs.und_s3 = cs.und_s2;
      next_cs.ovr_s1 = ls.ovr_t;
      next_cs.ovr_s2 = cs.ovr_s1;
      next_cs.ovr_s3 = cs.ovr_s2;
      // write one clears, a same-cycle event still sets
      next_cs.und = (cs.und & ~(wr_stat & wdata[astp_pkg::S_UND])) | (cs.und_s2 ^ cs.und_s3);
      next_cs.ovr = (cs.ovr & ~(wr_stat & wdata[astp_pkg::S_OVR])) | (cs.ovr_s2 ^ cs.ovr_s3);
      if (tx_valid && tx_ready) begin // RULE7
         next_cs.tx_hold = tx_data;
         next_cs.tx_req = ~cs.tx_req;
      end
      if (rx_valid && rx_ready) begin // RULE7
         next_cs.rx_ack = ~cs.rx_ack;
      end
      // codec clock divider, half period of mdiv+1 cycles
      if (cs.mcnt >= cs.mdiv) begin // RULE11
         next_cs.mcnt = '0;
         next_cs.mclk = ~cs.mclk;
      end else begin
         next_cs.mcnt = cs.mcnt + 1'b1;
      end
      if (wr) begin
         case (addr)
            astp_pkg::A_CTRL: next_cs.ctrl = wdata[8:0];
            astp_pkg::A_FRAME: next_cs.frame = wdata[13:0];
            astp_pkg::A_TXMASK: next_cs.txm = wdata[15:0]; // RULE4
            astp_pkg::A_RXMASK: next_cs.rxm = wdata[15:0]; // RULE4
            astp_pkg::A_MDIV: next_cs.mdiv = wdata[MDIV_W-1:0];
            default: begin
            end
         endcase
      end
      // read data stands only in the cycle after the strobe
      next_cs.rdata = '0;
      if (rd) begin
         case (addr)
            astp_pkg::A_CTRL: next_cs.rdata = {23'h0, cs.ctrl};
            astp_pkg::A_FRAME: next_cs.rdata = {18'h0, cs.frame};
            astp_pkg::A_TXMASK: next_cs.rdata = {16'h0, cs.txm};
            astp_pkg::A_RXMASK: next_cs.rdata = {16'h0, cs.rxm};
            astp_pkg::A_STAT: next_cs.rdata = {29'h0, cs.ovr, cs.und, cs.irq_s2}; // RULE11
            astp_pkg::A_MDIV: next_cs.rdata = 32'(cs.mdiv);
            default: next_cs.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cs <= '0;
         cs.ctrl <= astp_pkg::CTRL_RST;
         cs.frame <= astp_pkg::FRAME_RST;
         cs.txm <= astp_pkg::MASK_RST;
         cs.rxm <= astp_pkg::MASK_RST;
         cs.mdiv <= MDIV_W'(astp_pkg::MDIV_RST);
      end else begin
         cs <= next_cs;
      end
   end

   assign rdata = cs.rdata;
   assign tx_ready = cs.tx_req == cs.txa_s2;
   assign rx_valid = cs.rxr_s2 != cs.rx_ack;
   assign rx_data = ls.rx_hold; // held stable until acknowledged
   assign codec_master_clock = cs.mclk;
   assign codec_reset_out = cs.ctrl[astp_pkg::C_CRST]; // RULE11
   assign frame_sync_oe = mst; // RULE10
   assign bit_clk_oe = mst; // RULE10
   // no divider on the way out, so the pin runs at link_clk, 49.152 mhz at most
   assign bit_clk_out = link_clk; // RULE9

   ////////////////////////////////////////////////////////////////////
   // link reset: asserts at once, releases on link_clk
   always_ff @(posedge link_clk or negedge rstn) begin
      if (!rstn) begin
         lrst <= 2'h0;
      end else begin
         lrst <= {lrst[0], 1'b1};
      end
   end

   // slave frame start: i2s falls into the left slot, others rise
   assign l_start = !mst && ((fmt == astp_pkg::fmt_i2s) ? (!frame_sync_in && ls.fs_prev)
                                                       : (frame_sync_in && !ls.fs_prev)); // RULE12

   // bit counters, shifters and word crossings on the link clock
   always_comb begin
      logic [3:0] es;
      logic [4:0] eb;
      logic [5:0] rp;
      logic [5:0] tp;
      logic [31:0] sh;
      logic tsel;
      logic on;
      next_ls = ls;
      es = ls.slot;
      eb = ls.bitc;
      rp = '0;
      tp = '0;
      sh = ls.rx_sh;
      tsel = 1'b0;
      on = 1'b0;
      next_ls.en_s1 = cs.ctrl[astp_pkg::C_EN];
      next_ls.en_s2 = ls.en_s1;
      next_ls.txr_s1 = cs.tx_req;
      next_ls.txr_s2 = ls.txr_s1;
      next_ls.rxa_s1 = cs.rx_ack;
      next_ls.rxa_s2 = ls.rxa_s1;
      next_ls.fs_prev = frame_sync_in;
      if (l_start) begin // RULE12
         es = 4'h0;
         eb = 5'h00;
      end
      // receive the bit of the current position
      rp = dpos(fmt, eb, sw, wl);
      if (ls.lock && cs.ctrl[astp_pkg::C_RX] && cs.rxm[es]) begin // RULE4 RULE5 RULE8
         if (rp[5]) begin
            sh = {ls.rx_sh[30:0], serial_in};
         end
         next_ls.rx_sh = sh;
         if (eb == sw) begin
            next_ls.rx_sh = '0;
            if (ls.rx_req == ls.rxa_s2) begin // RULE7
               next_ls.rx_hold = sh;
               next_ls.rx_req = ~ls.rx_req;
            end else begin
               next_ls.ovr_t = ~ls.ovr_t;
            end
         end
      end
      // advance position; parked on the last bit while disabled
      if (!ls.en_s2) begin
         next_ls.slot = nsl;
         next_ls.bitc = sw;
         next_ls.lock = 1'b0;
      end else begin
         if (mst || l_start) begin
            next_ls.lock = 1'b1;
         end
         if (eb == sw) begin
            next_ls.bitc = 5'h00;
            next_ls.slot = (es >= nsl) ? 4'h0 : es + 4'h1; // RULE5
         end else begin
            next_ls.bitc = eb + 5'h01;
            next_ls.slot = es; // RULE12
         end
      end
      // transmit the next position; a missing word sends silence
      on = ls.en_s2 && cs.ctrl[astp_pkg::C_TX];
      tsel = on && next_ls.lock && cs.txm[next_ls.slot]; // RULE4 RULE8
      if (tsel && (next_ls.bitc == 5'h00)) begin
         if (ls.txr_s2 != ls.tx_ack) begin // RULE7
            next_ls.tx_word = cs.tx_hold;
            next_ls.tx_ack = ~ls.tx_ack;
         end else begin
            next_ls.tx_word = '0;
            next_ls.und_t = ~ls.und_t;
         end
      end
      tp = dpos(fmt, next_ls.bitc, sw, wl);
      next_ls.so = tsel && tp[5] && next_ls.tx_word[wl - tp[4:0]];
      next_ls.soe = on && (tsel || !cs.ctrl[astp_pkg::C_HIZ]); // RULE6
      next_ls.fs_o = ls.en_s2 && mst && fsv(fmt, next_ls.slot, next_ls.bitc); // RULE10
   end

   always_ff @(posedge link_clk or negedge rstn) begin
      if (!rstn) begin
         ls <= '0;
      end else if (!lrst[1]) begin
         ls <= '0;
      end else begin
         ls <= next_ls;
      end
   end

   assign frame_sync_out = ls.fs_o;
   assign serial_out = ls.so;
   assign serial_out_oe = ls.soe;

   ////////////////////////////////////////////////////////////////////
   // checks on the link clock
   sequence s_long;
      ls.fs_o ##1 !ls.fs_o;
   endsequence

   property p_short_pulse;
      @(posedge link_clk) disable iff (!lrst[1])
      (fmt == astp_pkg::fmt_pcm_short) && $rose(ls.fs_o) |=> !ls.fs_o;
   endproperty
   a_short_pulse: assert property (p_short_pulse) else $error("short pulse not one bit wide"); // RULE2

   property p_long_pulse;
      @(posedge link_clk) disable iff (!lrst[1])
      (fmt == astp_pkg::fmt_pcm_long) && $rose(ls.fs_o) |=> s_long;
   endproperty
   a_long_pulse: assert property (p_long_pulse) else $error("long pulse not two bits wide"); // RULE3

   property p_hiz;
      @(posedge link_clk) disable iff (!lrst[1])
      cs.ctrl[astp_pkg::C_HIZ] && !cs.txm[ls.slot] |-> !ls.soe;
   endproperty
   a_hiz: assert property (p_hiz) else $error("output driven in unselected slot"); // RULE6

   property p_slot_zero;
      @(posedge link_clk) disable iff (!lrst[1])
      ls.en_s2 && l_start && (sw != 5'h00) |=> (ls.slot == 4'h0) && (ls.bitc == 5'h01);
   endproperty
   a_slot_zero: assert property (p_slot_zero) else $error("frame pulse not at slot zero bit zero"); // RULE12

   property p_one_way;
      @(posedge link_clk) disable iff (!lrst[1])
      !cs.ctrl[astp_pkg::C_TX] |=> !ls.soe && !ls.so;
   endproperty
   a_one_way: assert property (p_one_way) else $error("output active with transmit off"); // RULE8

   // checks on the register clock
   property p_tx_take;
      @(posedge clk) disable iff (!rstn)
      tx_valid && tx_ready |=> !tx_ready ##1 !tx_ready;
   endproperty
   a_tx_take: assert property (p_tx_take) else $error("tx ready not dropped after a take"); // RULE7

   property p_rx_hold;
      @(posedge clk) disable iff (!rstn)
      rx_valid && !rx_ready |=> rx_valid && $stable(rx_data);
   endproperty
   a_rx_hold: assert property (p_rx_hold) else $error("rx word lost while stalled"); // RULE7

   property p_codec_reset;
      @(posedge clk) disable iff (!rstn)
      wr && (addr == astp_pkg::A_CTRL) |=> codec_reset_out == $past(wdata[astp_pkg::C_CRST]);
   endproperty
   a_codec_reset: assert property (p_codec_reset) else $error("codec reset not following control"); // RULE11

   // a slave never launches its own frame pulse
   property p_roles;
      @(posedge link_clk) disable iff (!lrst[1])
      !cs.ctrl[astp_pkg::C_MST] |=> !ls.fs_o;
   endproperty
   a_roles: assert property (p_roles) else $error("frame sync launched in slave role"); // RULE10
endmodule

// ===== bench/astp_codec_model.sv
/*
 partner codec for the serial audio port in slave role: makes frame sync,
 sends a random word in every slot, captures words from the port.
 assumes the bench makes link_clk and raises run on a rising link edge;
 16-bit slots, msb first.
*/
module astp_codec_model (
   input wire logic link_clk,
   input wire logic run,
   input wire logic fs_long,
   input wire logic [4:0] slots,
   input wire logic [15:0] tx_mask,
   input wire logic [15:0] rx_mask,
   input wire logic serial_out,
   input wire logic serial_out_oe,
   output logic frame_sync_in,
   output logic serial_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] rx_q[$];
   logic [15:0] tx_got[$];
   int tx_nz = 0;
   int stray = 0;
   int bit_i = 0;
   int slot_i = 0;
   logic [15:0] out_w = 16'h0000;
   logic [15:0] in_w = 16'h0000;
   initial begin
      frame_sync_in = 1'b0;
      serial_in = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // launch on the falling edge so sync and data are settled when sampled
   always @(negedge link_clk) begin
      if (!run) begin
         frame_sync_in <= 1'b0;
         serial_in <= ~serial_in; // idle line must not look like data
      end else begin
         if (bit_i == 0) begin
            out_w = 16'($urandom);
            if (rx_mask[slot_i]) rx_q.push_back(out_w);
         end
         frame_sync_in <= (slot_i == 0) && (bit_i == 0 || (fs_long && bit_i == 1));
         serial_in <= out_w[15 - bit_i];
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // capture on the rising edge; unselected slots must be released
   always @(posedge link_clk) begin
      if (run) begin
         in_w = {in_w[14:0], serial_out};
         if (!tx_mask[slot_i] && serial_out_oe) stray++;
         if (bit_i == 15) begin
            if (tx_mask[slot_i]) tx_got.push_back(in_w);
            if (tx_mask[slot_i] && in_w != 16'h0000) tx_nz++;
            bit_i = 0;
            slot_i = (slot_i == int'(slots) - 1) ? 0 : slot_i + 1;
         end else begin
            bit_i++;
         end
      end
   end
endmodule

// ===== bench/astp_top_tb.sv
/*
 self-checking bench: register map, master frame shapes for all formats,
 codec clock, reset and interrupt, then a slave duplex tdm run.
 assumes the design package, top module and codec model compile first.
*/
module astp_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic rstn = 1'b0;
   logic [4:0] addr = 5'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] tx_data = 32'h0;
   logic tx_valid = 1'b0;
   logic rx_ready = 1'b0;
   logic codec_interrupt_in = 1'b0;
   logic [31:0] rdata, rx_data;
   logic tx_ready, rx_valid, frame_sync_in, frame_sync_out, frame_sync_oe;
   logic bit_clk_out, bit_clk_oe, serial_in, serial_out, serial_out_oe;
   logic codec_master_clock, codec_reset_out;
   logic run = 1'b0;
   logic tx_go = 1'b0;
   logic [31:0] tx_words [0:8];
   logic [31:0] rx_exp;
   int miscompares = 0;
   int comparisons = 0;
   int tx_cnt = 0;
   int rx_seen = 0;
   int n, j, p;
   logic [4:0] r_adr [7] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14, 5'h18};
   logic [31:0] r_val [7] = '{32'h100, 32'h1ff1, 32'h3, 32'h3, 32'h0, 32'h1, 32'h0};
   int hi_t [5] = '{128, 128, 128, 4, 8};
   int ri_t [5] = '{8, 8, 8, 4, 4};

   always #5 clk = ~clk;
   // link clock offset so its edges never meet the register clock's
   initial begin
      #3.3;
      forever #32 link_clk = ~link_clk;
   end

   astp_top astp_top_inst (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .link_clk(link_clk), .frame_sync_in(frame_sync_in),
      .frame_sync_out(frame_sync_out), .frame_sync_oe(frame_sync_oe), .bit_clk_out(bit_clk_out),
      .bit_clk_oe(bit_clk_oe), .serial_in(serial_in), .serial_out(serial_out),
      .serial_out_oe(serial_out_oe), .codec_master_clock(codec_master_clock),
      .codec_reset_out(codec_reset_out), .codec_interrupt_in(codec_interrupt_in));
   astp_codec_model astp_codec_model_inst (.link_clk(link_clk), .run(run), .fs_long(1'b0),
      .slots(5'h04), .tx_mask(16'h0005), .rx_mask(16'h000a), .serial_out(serial_out),
      .serial_out_oe(serial_out_oe), .frame_sync_in(frame_sync_in), .serial_in(serial_in));

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [4:0] a, input logic [31:0] exp, input logic [31:0] m);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk($sformatf("rdata at %h", a), exp, rdata & m);
   endtask
   // clk cycles between two rising edges of the codec clock
   task automatic mclk_period(output int per);
      logic prev;
      prev = 1'b1;
      per = 0;
      repeat (2) begin
         per = 0;
         while (per < 100 && !(codec_master_clock === 1'b1 && prev === 1'b0)) begin
            prev = codec_master_clock;
            @(posedge clk);
            per++;
         end
         prev = 1'b1;
      end
   endtask
   // counts high bits and pulses over 256 bits from a pulse start
   task automatic frame_shape(input int f, input int exp_hi, input int exp_rise);
      int hi, rise, k;
      logic prev;
      hi = 0;
      rise = 0;
      k = 0;
      prev = 1'b1;
      wr_reg(astp_pkg::A_CTRL, 32'h0);
      // let the link park before the format changes
      repeat (4) @(posedge link_clk);
      wr_reg(astp_pkg::A_CTRL, 32'h3 | (f << astp_pkg::C_FMT));
      repeat (80) @(posedge link_clk);
      while (k < 200 && !(frame_sync_out === 1'b1 && prev === 1'b0)) begin
         prev = frame_sync_out;
         @(posedge link_clk);
         k++;
      end
      chk("frame start found", 1, k < 200);
      prev = 1'b0;
      repeat (256) begin
         if (frame_sync_out === 1'b1) hi++;
         if (frame_sync_out === 1'b1 && prev === 1'b0) rise++;
         prev = frame_sync_out;
         @(posedge link_clk);
      end
      chk($sformatf("sync high bits fmt %0d", f), exp_hi, hi);
      chk($sformatf("sync pulses fmt %0d", f), exp_rise, rise);
      chk("frame_sync_oe", 1, frame_sync_oe);
      chk("bit_clk_oe", 1, bit_clk_oe);
      #1;
      chk("bit_clk_out", 1, bit_clk_out);
   endtask
   task automatic close_out();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // sample stream with random pauses; a raised offer holds until taken
   always @(posedge clk) begin
      if (tx_valid && tx_ready) tx_cnt++;
      if (!tx_valid || tx_ready) begin
         tx_valid <= tx_go && tx_cnt < 8 && ($urandom_range(3) != 0);
         tx_data <= tx_words[tx_cnt];
      end
   end
   // received words against what the codec sent in receive slots
   always @(posedge clk) begin
      rx_ready <= ($urandom_range(1) == 1);
      if (rx_valid && rx_ready) begin
         rx_seen++;
         rx_exp = 32'hxxxxxxxx;
         if (astp_codec_model_inst.rx_q.size() > 0) rx_exp = {16'h0, astp_codec_model_inst.rx_q.pop_front()};
         chk("rx_data", rx_exp, rx_data);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h48a3eef8));
      for (int i = 0; i < 8; i++) tx_words[i] = {16'h0, 16'($urandom) | 16'h0001};
      tx_words[8] = 32'h0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      chk("codec_reset_out", 1, codec_reset_out);
      for (int i = 0; i < 7; i++) rd_reg(r_adr[i], r_val[i], 32'hffffffff);
      wr_reg(5'h18, 32'hffffffff);
      rd_reg(5'h18, 32'h0, 32'hffffffff);
      wr_reg(astp_pkg::A_TXMASK, 32'hffffffff);
      rd_reg(astp_pkg::A_TXMASK, 32'h0000ffff, 32'hffffffff);
      @(posedge clk);
      codec_interrupt_in <= 1'b1;
      repeat (4) @(posedge clk);
      rd_reg(astp_pkg::A_STAT, 32'h1, 32'h1);
      wr_reg(astp_pkg::A_MDIV, 32'h3);
      mclk_period(p);
      mclk_period(p);
      chk("codec clock period", 8, p);
      wr_reg(astp_pkg::A_CTRL, 32'h0);
      #1;
      chk("codec_reset_out", 0, codec_reset_out);
      // master role, every format, 16-bit slots, four in the pcm formats and two in i2s and justified
      wr_reg(astp_pkg::A_FRAME, 32'h0ef3);
      for (int f = 0; f < 5; f++) frame_shape(f, hi_t[f], ri_t[f]);
      // slave role, pcm short pulse, tx slots 0 and 2, rx slots 1 and 3
      wr_reg(astp_pkg::A_CTRL, 32'h0);
      wr_reg(astp_pkg::A_FRAME, 32'h1ef3);
      wr_reg(astp_pkg::A_TXMASK, 32'h5);
      wr_reg(astp_pkg::A_RXMASK, 32'ha);
      wr_reg(astp_pkg::A_CTRL, 32'h7d);
      repeat (8) @(posedge link_clk);
      chk("slave frame_sync_oe", 0, frame_sync_oe);
      chk("slave bit_clk_oe", 0, bit_clk_oe);
      run <= 1'b1;
      repeat (192) @(posedge link_clk);
      @(posedge clk);
      tx_go <= 1'b1;
      n = 0;
      while (n < 20000 && (astp_codec_model_inst.tx_nz < 8 || rx_seen < 12)) begin
         @(posedge clk);
         n++;
      end
      chk("duplex run finished", 1, n < 20000);
      j = 0;
      foreach (astp_codec_model_inst.tx_got[i]) begin
         if (astp_codec_model_inst.tx_got[i] != 16'h0000 && j < 8) begin
            chk("serial word", tx_words[j], {16'h0, astp_codec_model_inst.tx_got[i]});
            j++;
         end
      end
      chk("words sent", 8, j);
      chk("driven in released slots", 0, astp_codec_model_inst.stray);
      rd_reg(astp_pkg::A_STAT, 32'h2, 32'h2);
      close_out();
   end
endmodule
